// ==== verilog/adc_ctrl_regs.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  converter sequencing control block.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define OFF_CONTROL0 12'h000
`define OFF_CONTROL1 12'h004
`define OFF_RESULT 12'h008
`define OFF_PINSHARE 12'h00c
`define OFF_STATUS 12'h010

`define C0_START 7
`define C0_BUSY 6
`define C0_ENABLE 5
`define C0_FORMAT 4
`define C0_CHAN_LSB 0
`define C1_INSRC_LSB 5
`define C1_REFSEL_LSB 3
`define C1_DIV_LSB 0
`define PS_ANALOG_LSB 0
`define PS_REFPIN 4
`define ST_IRQ 0

`define CONTROL0_RESET 8'h00
`define CONTROL1_RESET 8'h00
`define PINSHARE_RESET 5'h00

`define SAMPLE_CYCLES 5'h04
`define TOTAL_CYCLES 5'h10
`define RESULT_BITS 12

`endif

// ==== verilog/adc_ctrl_pkg.sv ====
/*
  Types shared by the converter control block and its submodules.
  Assumes nothing beyond a SystemVerilog tool.
*/
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    conv_idle,
    conv_sample,
    conv_convert
  } conv_state_t;

  typedef enum logic [2:0] {
    src_external,
    src_bandgap,
    src_amp0,
    src_amp1,
    src_line
  } analog_source_t;
endpackage

// ==== verilog/conv_clock_div.sv ====
/*
  Conversion clock prescaler: one-cycle enable pulse at aclk divided by
  1 to 128. Assumes a single aclk domain with synchronous reset.
*/
module conv_clock_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] conv_clk_div_sel,
  output logic conv_tick
);
  logic [6:0] count;
  logic [6:0] limit;

  // Code n divides by 2 to the n
  assign limit = 7'(({7'h00, 1'b1} << conv_clk_div_sel) - 8'h01);
  assign conv_tick = run && (count >= limit);

  // Held in reset while stopped so every conversion starts on a fresh phase
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || conv_tick) begin
      count <= 7'h00;
    end else begin
      count <= count + 7'h01;
    end
  end
endmodule

// ==== verilog/conv_sequencer.sv ====
/*
  Conversion sequencer: counts sample and convert phases on conversion
  clock ticks and captures the result. Assumes tick is a one-cycle enable.
*/
`include "adc_ctrl_regs.svh"

module conv_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic enable,
  input wire logic conv_tick,
  input wire logic [11:0] analog_result,
  output logic busy,
  output logic done,
  output logic [11:0] result
);
  adc_ctrl_pkg::conv_state_t state;
  adc_ctrl_pkg::conv_state_t next_state;
  logic [4:0] cycles;
  logic last_tick;

  assign last_tick = conv_tick && (cycles == `TOTAL_CYCLES - 5'h01);
  assign busy = (state != adc_ctrl_pkg::conv_idle);

  always_comb begin
    next_state = state;
    case (state)
      adc_ctrl_pkg::conv_idle: begin
        if (start && enable) begin
          next_state = adc_ctrl_pkg::conv_sample;
        end
      end
      adc_ctrl_pkg::conv_sample: begin
        if (conv_tick && cycles == `SAMPLE_CYCLES - 5'h01) begin
          next_state = adc_ctrl_pkg::conv_convert;
        end
      end
      adc_ctrl_pkg::conv_convert: begin
        if (last_tick) begin
          next_state = adc_ctrl_pkg::conv_idle;
        end
      end
      default: next_state = adc_ctrl_pkg::conv_idle;
    endcase
    if (!enable) begin
      next_state = adc_ctrl_pkg::conv_idle;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= adc_ctrl_pkg::conv_idle;
      cycles <= 5'h00;
      done <= 1'b0;
      result <= 12'h000;
    end else begin
      state <= next_state;
      done <= enable && last_tick && state == adc_ctrl_pkg::conv_convert;
      if (state == adc_ctrl_pkg::conv_idle) begin
        cycles <= 5'h00;
      end else if (conv_tick) begin
        cycles <= cycles + 5'h01;
      end
      // Result only moves on a finished conversion, so power-down keeps it
      if (enable && last_tick && state == adc_ctrl_pkg::conv_convert) begin
        result <= analog_result;
      end
    end
  end
endmodule

// ==== verilog/adc_sequencing_control.sv ====
/*
  Converter sequencing control: AXI4-Lite register file, start handshake,
  busy flag, completion request, power enable, reference and input
  selection, pin-function overrides.
  Assumes an AXI4-Lite master on aclk and an analog core that samples its
  input while sample_phase is high and presents a 12-bit code at the end.
*/
// The AXI4-Lite slave port and the address map were decided locally.
`include "adc_ctrl_regs.svh"

module adc_sequencing_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] analog_result,
  input wire logic [3:0] port_dir_in,
  input wire logic [3:0] port_pullup_en,
  output logic conv_power_enable,
  output logic sample_phase,
  output logic conv_clock_tick,
  output logic reference_from_supply,
  output logic [2:0] analog_source,
  output logic [3:0] analog_pin_inputs,
  output logic [3:0] pin_digital_enable,
  output logic [3:0] pin_dir_in,
  output logic [3:0] pin_pullup_en,
  output logic ref_pin_share_bits,
  output logic conv_done_irq
);
  logic [7:0] conv_control_reg0;
  logic [7:0] conv_control_reg1;
  logic [4:0] pin_share;
  logic irq_flag;
  logic start_armed;
  logic start_pulse;
  logic conv_busy_flag;
  logic conv_done;
  logic conv_tick;
  logic [11:0] result;
  logic [3:0] external_channel_sel;
  logic [2:0] input_source_sel;
  logic [1:0] reference_source_sel;
  logic [2:0] conv_clk_div_sel;
  logic [3:0] analog_pins;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_byte0;
  logic wr_c0;
  logic wr_c1;
  logic wr_ps;
  logic wr_st;
  logic wr_ok;
  logic rd_c0;
  logic rd_c1;
  logic rd_res;
  logic rd_ps;
  logic rd_st;
  logic rd_ok;
  logic [31:0] rd_word;
  logic [15:0] result_fmt;
  logic [7:0] c0_view;
  logic [11:0] ar_word;

  assign external_channel_sel = conv_control_reg0[`C0_CHAN_LSB +: 4];
  assign input_source_sel = conv_control_reg1[`C1_INSRC_LSB +: 3];
  assign reference_source_sel = conv_control_reg1[`C1_REFSEL_LSB +: 2];
  assign conv_clk_div_sel = conv_control_reg1[`C1_DIV_LSB +: 3];
  assign analog_pins = pin_share[`PS_ANALOG_LSB +: 4];

  // Write channel: address and data taken independently, in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_byte0 = wr_fire && w_strb[0];
  assign wr_c0 = (aw_addr == `OFF_CONTROL0);
  assign wr_c1 = (aw_addr == `OFF_CONTROL1);
  assign wr_ps = (aw_addr == `OFF_PINSHARE);
  assign wr_st = (aw_addr == `OFF_STATUS);
  assign wr_ok = wr_c0 || wr_c1 || wr_ps || wr_st || (aw_addr == `OFF_RESULT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Busy bit is read-only; software writes to it are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_control_reg0 <= `CONTROL0_RESET;
      conv_control_reg1 <= `CONTROL1_RESET;
      pin_share <= `PINSHARE_RESET;
    end else if (wr_byte0) begin
      if (wr_c0) begin
        conv_control_reg0 <= {w_data[7], 1'b0, w_data[5:0]};
      end
      if (wr_c1) begin
        conv_control_reg1 <= w_data[7:0];
      end
      if (wr_ps) begin
        pin_share <= w_data[4:0];
      end
    end
  end

  // Only a high-then-low sequence counts; a level left high does nothing
  assign start_pulse = start_armed && !conv_control_reg0[`C0_START];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_armed <= 1'b0;
    end else if (conv_control_reg0[`C0_START]) begin
      start_armed <= 1'b1;
    end else begin
      start_armed <= 1'b0;
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag <= 1'b0;
    end else if (conv_done) begin
      irq_flag <= 1'b1;
    end else if (wr_byte0 && wr_st && w_data[`ST_IRQ]) begin
      irq_flag <= 1'b0;
    end
  end
  assign conv_done_irq = irq_flag;

  conv_clock_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(conv_busy_flag && conv_control_reg0[`C0_ENABLE]),
    .conv_clk_div_sel(conv_clk_div_sel),
    .conv_tick(conv_tick)
  );

  conv_sequencer u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_pulse && !conv_busy_flag),
    .enable(conv_control_reg0[`C0_ENABLE]),
    .conv_tick(conv_tick),
    .analog_result(analog_result),
    .busy(conv_busy_flag),
    .done(conv_done),
    .result(result)
  );

  // Sample strobe lasts one aclk cycle, the cycle after an accepted start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_phase <= 1'b0;
    end else begin
      sample_phase <= start_pulse && !conv_busy_flag && conv_control_reg0[`C0_ENABLE];
      if (sample_phase || conv_busy_flag) begin
        sample_phase <= 1'b0;
      end
    end
  end
  assign conv_clock_tick = conv_tick;

  assign conv_power_enable = conv_control_reg0[`C0_ENABLE];
  assign reference_from_supply = (reference_source_sel == 2'b01);
  assign ref_pin_share_bits = pin_share[`PS_REFPIN];

  always_comb begin
    case (input_source_sel)
      3'h1: analog_source = 3'(adc_ctrl_pkg::src_bandgap);
      3'h2: analog_source = 3'(adc_ctrl_pkg::src_amp0);
      3'h3: analog_source = 3'(adc_ctrl_pkg::src_amp1);
      3'h4: analog_source = 3'(adc_ctrl_pkg::src_line);
      default: analog_source = 3'(adc_ctrl_pkg::src_external);
    endcase
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pin
      // Switch closes only for an assigned analog pin; codes 4..15 float
      assign analog_pin_inputs[i] = analog_pins[i] &&
        (external_channel_sel == 4'(i));
      assign pin_digital_enable[i] = !analog_pins[i];
      assign pin_pullup_en[i] = port_pullup_en[i] && !analog_pins[i];
      assign pin_dir_in[i] = port_dir_in[i] || analog_pins[i];
    end
  endgenerate

  // Read path
  assign result_fmt = conv_control_reg0[`C0_FORMAT] ? {4'h0, result} : {result, 4'h0};
  assign c0_view = {conv_control_reg0[7], conv_busy_flag, conv_control_reg0[5:0]};
  assign ar_word = {s_axi_araddr[11:2], 2'b00};
  assign rd_c0 = (ar_word == `OFF_CONTROL0);
  assign rd_c1 = (ar_word == `OFF_CONTROL1);
  assign rd_res = (ar_word == `OFF_RESULT);
  assign rd_ps = (ar_word == `OFF_PINSHARE);
  assign rd_st = (ar_word == `OFF_STATUS);
  assign rd_ok = rd_c0 || rd_c1 || rd_res || rd_ps || rd_st;
  assign rd_word = rd_c0 ? {24'h000000, c0_view} :
    rd_c1 ? {24'h000000, conv_control_reg1} :
    rd_res ? {16'h0000, result_fmt} :
    rd_ps ? {27'h0000000, pin_share} :
    rd_st ? {31'h00000000, irq_flag} : 32'h0000_0000;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== sim/adc_seq_props.sv ====
/* Port checker for the converter sequencing control block.
   Assumes a bind to the top module and a single aclk domain. */
module adc_seq_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] port_dir_in,
  input wire logic [3:0] port_pullup_en,
  input wire logic conv_power_enable,
  input wire logic sample_phase,
  input wire logic conv_clock_tick,
  input wire logic [2:0] analog_source,
  input wire logic [3:0] analog_pin_inputs,
  input wire logic [3:0] pin_digital_enable,
  input wire logic [3:0] pin_dir_in,
  input wire logic [3:0] pin_pullup_en,
  input wire logic conv_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [4:0] ticks;
  // A tick in the start cycle still counts, so the reload keeps it
  always_ff @(posedge aclk)
    if (!aresetn) ticks <= 5'h00;
    else if (sample_phase) ticks <= {4'h0, conv_clock_tick};
    else ticks <= ticks + {4'h0, conv_clock_tick};
  dir_override_a: assert property (
    pin_dir_in == (port_dir_in | ~pin_digital_enable)) else $error("direction not overridden");
  pullup_off_a: assert property (
    pin_pullup_en == (port_pullup_en & pin_digital_enable)) else $error("pull-high kept");
  pin_exclusive_a: assert property (
    (analog_pin_inputs & pin_digital_enable) == 4'h0) else $error("digital pin switched in");
  chan_onehot_a: assert property (
    $onehot0(analog_pin_inputs)) else $error("two channels on");
  tick_power_a: assert property (
    conv_clock_tick |-> conv_power_enable) else $error("tick while powered down");
  sample_pulse_a: assert property (
    sample_phase |=> !sample_phase) else $error("start pulse too long");
  conv_length_a: assert property (
    $rose(conv_done_irq) |-> ticks == 5'h10) else $error("wrong tick count");
  done_idle_a: assert property (
    $rose(conv_done_irq) |-> !conv_clock_tick) else $error("ticks after done");
  src_range_a: assert property (
    analog_source <= 3'h4) else $error("bad source code");
  cover property ($rose(conv_done_irq));
  cover property (sample_phase);
  cover property (|analog_pin_inputs);
endmodule

// ==== sim/adc_sequencing_control_bench.sv ====
/* Self-checking bench for the converter sequencing control block.
   Assumes the design files are compiled first; drives AXI4-Lite itself. */
module adc_sequencing_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr, analog_result, res;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, port_dir_in, port_pullup_en, analog_pin_inputs, ch;
  logic [3:0] pin_digital_enable, pin_dir_in, pin_pullup_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] analog_source;
  logic [2:0] divs [4];
  logic [4:0] ps;
  logic [7:0] c0;
  logic conv_power_enable, sample_phase, conv_clock_tick;
  logic reference_from_supply, ref_pin_share_bits, conv_done_irq;
  int fail_count, checks_done, cyc, nticks, t_first, t_last;

  adc_sequencing_control uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .analog_result, .port_dir_in, .port_pullup_en, .conv_power_enable,
    .sample_phase, .conv_clock_tick, .reference_from_supply, .analog_source,
    .analog_pin_inputs, .pin_digital_enable, .pin_dir_in, .pin_pullup_en,
    .ref_pin_share_bits, .conv_done_irq);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog and tick monitor share one cycle count
  always @(posedge aclk) begin
    cyc++;
    if (conv_clock_tick === 1'b1) begin
      nticks++;
      if (nticks == 1) t_first = cyc;
      t_last = cyc;
    end
    if (cyc == 60000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [2:0] exp_src(input logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h4) ? c : 3'h0;
  endfunction

  function automatic logic [3:0] exp_pins(input logic [3:0] p, input logic [3:0] c);
    return (c < 4'h4 && p[c[1:0]]) ? 4'h1 << c[1:0] : 4'h0;
  endfunction

  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, analog_result} = '0;
    {port_dir_in, port_pullup_en} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    divs = '{3'h0, 3'h1, 3'h3, 3'h7};
    void'($urandom(32'hf412c787));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      rdr(12'(a * 4));
      chk("reset value", 32'h0, rd);
    end
    rdr(12'h014);
    chk("unmapped rresp", 32'h2, resp);
    wr(12'h014, 32'h0);
    chk("unmapped bresp", 32'h2, resp);
    wr(12'h000, 32'h0000_000f);
    for (int c = 0; c < 8; c++) begin
      wr(12'h004, {24'h0, c[2:0], c[1:0], 3'h0});
      chk("source", exp_src(c[2:0]), analog_source);
      chk("supply ref", c[1:0] == 2'h1, reference_from_supply);
    end
    repeat (12) begin
      ps = 5'($urandom);
      ch = 4'($urandom_range(0, 7));
      port_dir_in <= 4'($urandom);
      port_pullup_en <= 4'($urandom);
      wr(12'h00c, {27'h0, ps});
      wr(12'h000, {28'h0, ch});
      chk("analog pins", exp_pins(ps[3:0], ch), analog_pin_inputs);
      chk("digital en", 4'(~ps[3:0]), pin_digital_enable);
      chk("direction", port_dir_in | ps[3:0], pin_dir_in);
      chk("pull-high", port_pullup_en & 4'(~ps[3:0]), pin_pullup_en);
      chk("ref pin", ps[4], ref_pin_share_bits);
    end
    for (int i = 0; i < 4; i++) begin
      res = 12'($urandom);
      analog_result <= res;
      c0 = i[0] ? 8'h30 : 8'h20;
      wr(12'h004, {29'h0, divs[i]});
      wr(12'h000, {24'h0, c0});
      chk("power on", 32'h1, conv_power_enable);
      repeat (8) @(posedge aclk);
      nticks = 0;
      wr(12'h000, {24'h0, c0 | 8'h80});
      rdr(12'h000);
      chk("busy on level", 32'h0, rd[6]);
      wr(12'h000, {24'h0, c0});
      rdr(12'h000);
      chk("busy", 32'h1, rd[6]);
      // Second start pulse while busy, for all but the fastest divider
      if (i > 0) begin
        wr(12'h000, {24'h0, c0 | 8'h80});
        wr(12'h000, {24'h0, c0});
      end
      while (rd[6] !== 1'b0) rdr(12'h000);
      chk("ticks", 32'd16, nticks);
      chk("tick span", 32'(15 << divs[i]), t_last - t_first);
      rdr(12'h008);
      chk("result", i[0] ? {20'h0, res} : {16'h0, res, 4'h0}, rd);
      rdr(12'h010);
      chk("irq flag", 32'h1, rd);
      chk("irq out", 32'h1, conv_done_irq);
      wr(12'h010, 32'h1);
      rdr(12'h010);
      chk("irq clear", 32'h0, rd);
    end
    // Power-down in mid-conversion: result and request must stay put
    analog_result <= ~res;
    wr(12'h000, 32'h0000_00b0);
    wr(12'h000, 32'h0000_0030);
    wr(12'h000, 32'h0000_0010);
    chk("power off", 32'h0, conv_power_enable);
    repeat (40) @(posedge aclk);
    rdr(12'h008);
    chk("held result", {20'h0, res}, rd);
    chk("irq on abort", 32'h0, conv_done_irq);
    rdr(12'h000);
    chk("busy on abort", 32'h0, rd[6]);
    give_verdict();
  end
endmodule

bind adc_sequencing_control adc_seq_props chk_i (.aclk, .aresetn, .port_dir_in,
  .port_pullup_en, .conv_power_enable, .sample_phase, .conv_clock_tick,
  .analog_source, .analog_pin_inputs, .pin_digital_enable, .pin_dir_in,
  .pin_pullup_en, .conv_done_irq);
